// ===== bench/cps_check_program_select_io_tb.sv
// self-checking bench for the check program select block
// assumes cps_ctrl_model drives the pins; delay scale shortened to 4 cycles per ms
module cps_check_program_select_io_tb;
	import cps_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CPM = 4;
	localparam int WDOG = 4000; // run needs about 610 cycles
	logic sys_clk, rst, serviceMode, autoChangeEn, cfgWrEn, cfgProg, measValid;
	logic [15:0] delayMs;
	logic signed [15:0] cfgOffsetX, cfgOffsetY, measX, measY;
	logic [7:0] cfgTolX, cfgTolY, cfgDiameter;
	logic trigger_line, program_select_low, program_select_high, programChangeLine;
	logic fault_image_line, pos_out_neg_x, pos_out_pos_x, pos_out_pos_y, pos_out_neg_y;
	logic activeProgram, changeBusy, cfgReject, undefinedSel;
	logic readingGateOpen, programStart, faultMemActive, imageWriteStart;
	logic [31:0] seed = 32'hae8de207;
	int errCount = 0;
	int testsRun = 0;
	cps_check_program_select_io #(.CYC_PER_MS(CPM)) u_cps_check_program_select_io (
		.sys_clk, .rst, .serviceMode, .autoChangeEn, .delayMs, .cfgWrEn, .cfgProg,
		.cfgOffsetX, .cfgOffsetY, .cfgTolX, .cfgTolY, .cfgDiameter, .measValid, .measX,
		.measY, .trigger_line, .program_select_low, .program_select_high,
		.programChangeLine, .fault_image_line, .pos_out_neg_x, .pos_out_pos_x,
		.pos_out_pos_y, .pos_out_neg_y, .activeProgram, .changeBusy, .cfgReject,
		.undefinedSel, .readingGateOpen, .programStart, .faultMemActive, .imageWriteStart
	);
	cps_ctrl_model u_cps_ctrl_model (
		.sys_clk, .trigger_line, .program_select_low, .program_select_high,
		.programChangeLine, .fault_image_line
	);
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// outputs in order -x +x +y -y; dx, dy doubled so odd limits stay exact
	function automatic logic [3:0] expPos(input int dx, input int dy, input int lx, input int ly);
		if (dx <= lx && -dx <= lx && dy <= ly && -dy <= ly)
			return 4'hf;
		return {dx < -lx, dx > lx, dy > ly, dy < -ly};
	endfunction
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		testsRun++;
		if (g !== e) begin
			errCount++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic meas(input logic signed [15:0] x, input logic signed [15:0] y,
		input logic [3:0] e);
		@(negedge sys_clk);
		measX = x;
		measY = y;
		measValid = 1'h1;
		@(negedge sys_clk);
		measValid = 1'h0;
		@(negedge sys_clk);
		chk("pos", e, {pos_out_neg_x, pos_out_pos_x, pos_out_pos_y, pos_out_neg_y});
	endtask
	task automatic measRand(input int ox, input int oy, input int lx, input int ly);
		int x, y;
		for (int i = 0; i < 12; i++) begin
			x = int'(rnd() % 40) - 20 + ox;
			y = int'(rnd() % 40) - 20 + oy;
			meas(16'(x), 16'(y), expPos(2 * (x - ox), 2 * (y - oy), lx, ly));
		end
	endtask
	// both accuracies take t; rl says the write hits the active program and reloads it
	task automatic cfg(input logic p, input logic signed [15:0] ox,
		input logic signed [15:0] oy, input logic [7:0] t, input logic [7:0] d,
		input logic rj, input logic rl);
		logic seen;
		logic [3:0] busy;
		busy = 4'h0;
		@(negedge sys_clk);
		cfgProg = p;
		cfgOffsetX = ox;
		cfgOffsetY = oy;
		cfgTolX = t;
		cfgTolY = t;
		cfgDiameter = d;
		cfgWrEn = 1'h1;
		@(negedge sys_clk);
		cfgWrEn = 1'h0;
		seen = cfgReject;
		busy = busy + changeBusy;
		@(negedge sys_clk);
		seen = seen | cfgReject;
		busy = busy + changeBusy;
		chk("cfgReject", {3'h0, rj}, {3'h0, seen});
		// let a reload settle while counting its busy cycles
		repeat (6) begin
			@(negedge sys_clk);
			busy = busy + changeBusy;
		end
		chk("changeBusy", rl ? 4'h3 : 4'h0, busy);
	endtask
	// random far-program words, each measured against its own area
	task automatic cfgRand();
		int ox, oy, t, d;
		for (int k = 0; k < 3; k++) begin
			ox = int'(rnd() % 21) - 10;
			oy = int'(rnd() % 21) - 10;
			t = int'(rnd() % 6) + 2;
			d = int'(rnd() % 30) + 2;
			serviceMode = 1'h1;
			cfg(1'h1, 16'(ox), 16'(oy), 8'(t), 8'(d), 1'h0, 1'h1);
			serviceMode = 1'h0;
			measRand(ox, oy, d + 2 * t, d + 2 * t);
		end
	endtask
	// stay: hold 40 cycles then check; else stop as soon as the program matches
	task automatic waitProg(input logic e, input logic stay);
		for (int i = 0; i < 40 && (stay || activeProgram !== e); i++)
			@(negedge sys_clk);
		chk("activeProgram", {3'h0, e}, {3'h0, activeProgram});
	endtask
	task automatic lineChk(input logic svc);
		logic [3:0] pulses;
		pulses = 4'h0;
		u_cps_ctrl_model.setLines(1'h1, 1'h1);
		repeat (6) begin
			@(negedge sys_clk);
			pulses = pulses + programStart + imageWriteStart;
		end
		chk("lines", {2'h0, !svc, !svc}, {2'h0, readingGateOpen, faultMemActive});
		chk("starts", svc ? 4'h0 : 4'h2, pulses);
		u_cps_ctrl_model.setLines(1'h0, 1'h0);
	endtask
	initial begin
		#(WDOG * 50);
		errCount++;
		close_out();
	end
	initial begin
		{rst, serviceMode, autoChangeEn, cfgWrEn, cfgProg, measValid} = 6'h20;
		{delayMs, cfgOffsetX, cfgOffsetY, measX, measY} = 80'h0;
		{cfgTolX, cfgTolY, cfgDiameter} = {8'h05, 8'h05, 8'h14};
		repeat (6) @(negedge sys_clk);
		rst = 1'h0;
		chk("resetOut", 4'h0, {pos_out_neg_x, pos_out_pos_x, activeProgram, changeBusy});
		// stored defaults give a 25 mm square
		meas(16'sd12, -16'sd12, 4'hf);
		meas(16'sd13, 16'sd0, 4'h4);
		measRand(0, 0, 25, 25);
		$display("test positioning defaults done");
		cfg(1'h0, 16'sd10, -16'sd6, 8'h03, 8'h14, 1'h1, 1'h0);
		serviceMode = 1'h1;
		meas(16'sd0, 16'sd0, 4'h0);
		cfg(1'h0, 16'sd10, -16'sd6, 8'h03, 8'h14, 1'h0, 1'h1);
		cfg(1'h0, 16'sd0, 16'sd0, 8'h01, 8'h14, 1'h1, 1'h0);
		cfg(1'h1, 16'sd0, 16'sd0, 8'h02, 8'h14, 1'h0, 1'h0);
		lineChk(1'h1);
		serviceMode = 1'h0;
		measRand(10, -6, 26, 26);
		lineChk(1'h0);
		$display("test config and lines done");
		autoChangeEn = 1'h1;
		delayMs = 16'(rnd() % 3) + 16'h0001; // one to three ms, still inside the wait limit
		// a glitch shorter than the delay must not switch
		u_cps_ctrl_model.setSel(2'h1);
		repeat (2) @(negedge sys_clk);
		u_cps_ctrl_model.setSel(2'h0);
		waitProg(1'h0, 1'h1);
		u_cps_ctrl_model.setSel(2'h1);
		waitProg(1'h1, 1'h0);
		measRand(0, 0, 24, 24);
		u_cps_ctrl_model.setSel(2'h2);
		waitProg(1'h1, 1'h1);
		chk("undefinedSel", 4'h1, {3'h0, undefinedSel});
		u_cps_ctrl_model.setSel(2'h3);
		waitProg(1'h1, 1'h1);
		u_cps_ctrl_model.setSel(2'h0);
		waitProg(1'h0, 1'h0);
		$display("test automatic change done");
		delayMs = 16'h0000;
		u_cps_ctrl_model.setSel(2'h1);
		waitProg(1'h0, 1'h1);
		delayMs = 16'h0001;
		autoChangeEn = 1'h0;
		waitProg(1'h0, 1'h1);
		u_cps_ctrl_model.confirm();
		waitProg(1'h1, 1'h0);
		serviceMode = 1'h1;
		u_cps_ctrl_model.setSel(2'h0);
		u_cps_ctrl_model.confirm();
		waitProg(1'h1, 1'h1);
		$display("test manual change done");
		cfgRand();
		// a second reset in mid-run must bring back the near program and the stored defaults
		@(negedge sys_clk);
		rst = 1'h1;
		repeat (2) @(negedge sys_clk);
		rst = 1'h0;
		chk("resetOut", 4'h0, {pos_out_neg_x, pos_out_pos_x, activeProgram, changeBusy});
		meas(16'sd12, -16'sd12, 4'hf);
		meas(16'sd13, 16'sd0, 4'h4);
		$display("test random config and reset done");
		close_out();
	end
endmodule

// ===== bench/cps_ctrl_model.sv
// storage machine control model: drives the camera's switching lines
// assumes the bench calls its tasks; lines change at falling clock edges
module cps_ctrl_model (
	input wire logic sys_clk,
	output logic trigger_line,
	output logic program_select_low,
	output logic program_select_high,
	output logic programChangeLine,
	output logic fault_image_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// the control always drives its lines, so idle is a firm low
	initial begin
		{trigger_line, program_select_high, program_select_low} = 3'h0;
		{programChangeLine, fault_image_line} = 2'h0;
	end
	// level stays until the next call, so the caller owns the hold time
	task automatic setSel(input logic [1:0] id);
		@(negedge sys_clk);
		{program_select_high, program_select_low} = id;
	endtask
	// two-cycle pulse so the synchroniser cannot miss it
	task automatic confirm();
		@(negedge sys_clk);
		programChangeLine = 1'h1;
		repeat (2) @(negedge sys_clk);
		programChangeLine = 1'h0;
	endtask
	task automatic setLines(input logic trig, input logic flt);
		@(negedge sys_clk);
		trigger_line = trig;
		fault_image_line = flt;
	endtask
endmodule

// ===== hw/cps_check_program_select_io.sv
// check program selection from two switching inputs and four fine-positioning outputs
// assumes switching lines arrive asynchronously; config and measurement ports are on sys_clk
// Contract
// - configuration writes are refused unless the device is in service mode
// - select id = {high input, low input}; 0 near, 1 far, 2 and 3 undefined
// - all four positioning outputs go to 1 when marking lies inside tolerance area
// - target is marking centre shifted by the programmed offsets
// - with automatic change on, the selection inputs switch program in process mode
// - removed selection signals read as low, so program id 0 gets activated
// - with automatic change off, a program-change confirmation input triggers the switch
// - a change needs the selection levels stable for the whole delay time
// - delay time of zero disables automatic change like clearing the setting
// - a changeover completes within 300 ms of being accepted
// - the first switching line starts the program and opens or closes the reading gate
// - the fourth switching line activates fault-image memory writes into a ring buffer
// - switching lines five to eight are outputs carrying the positioning results
// - positioning tolerance limits below 2 mm are refused
// - positioning outputs are negative X, positive X, positive Y, negative Y
// - service mode deactivates all switching lines and process communication
`include "cps_regs.svh"
module cps_check_program_select_io
	import cps_pkg::*;
#(
	parameter int CYC_PER_MS = `CPS_CYC_PER_MS
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic serviceMode,
	input wire logic autoChangeEn,
	input wire logic [15:0] delayMs,
	input wire logic cfgWrEn,
	input wire logic cfgProg,
	input wire logic signed [15:0] cfgOffsetX,
	input wire logic signed [15:0] cfgOffsetY,
	input wire logic [7:0] cfgTolX,
	input wire logic [7:0] cfgTolY,
	input wire logic [7:0] cfgDiameter,
	input wire logic measValid,
	input wire logic signed [15:0] measX,
	input wire logic signed [15:0] measY,
	input wire logic trigger_line,
	input wire logic program_select_low,
	input wire logic program_select_high,
	input wire logic programChangeLine,
	input wire logic fault_image_line,
	output logic pos_out_neg_x,
	output logic pos_out_pos_x,
	output logic pos_out_pos_y,
	output logic pos_out_neg_y,
	output logic activeProgram,
	output logic changeBusy,
	output logic cfgReject,
	output logic undefinedSel,
	output logic readingGateOpen,
	output logic programStart,
	output logic faultMemActive,
	output logic imageWriteStart
);
	// synchroniser stages: [0] trigger, [1] sel low, [2] sel high, [3] confirm, [4] fault
	logic [4:0] pinMeta_q;
	logic [4:0] pinSync_q;
	logic [4:0] pinPrev_q;
	logic [31:0] stableCnt_q;
	cps_sel_t selPrev_q;
	cps_sel_t selSync;
	logic [31:0] delayCyc;
	logic qualified;
	logic autoEff;
	logic confirmRise;
	logic accept;
	cps_chg_state_t state_q;
	logic targetProg_q;
	logic reloadReq;
	logic tolBad;
	logic memRd;
	logic [`CPS_CFG_W-1:0] memRdData;
	logic [`CPS_CFG_W-1:0] activeCfg_q;
	logic signed [15:0] offX;
	logic signed [15:0] offY;
	logic [7:0] tolX;
	logic [7:0] tolY;
	logic [7:0] diam;
	logic signed [17:0] devX2;
	logic signed [17:0] devY2;
	logic signed [17:0] limX;
	logic signed [17:0] limY;
	logic insideX;
	logic insideY;

	// every pin crosses two flops; the second stage and its one-cycle-delayed copy (edge detect) feed logic
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pinMeta_q <= 5'h00;
			pinSync_q <= 5'h00;
			pinPrev_q <= 5'h00;
		end else begin
			pinMeta_q <= {fault_image_line, programChangeLine, program_select_high,
				program_select_low, trigger_line};
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
		end
	end

	// open inputs are expected to read low here, which lands on id 0
	assign selSync = {pinSync_q[2], pinSync_q[1]};
	assign delayCyc = 32'(delayMs) * 32'(CYC_PER_MS);
	// the count still holds its old value on the cycle the selection moves, so gate on that too
	assign qualified = (selSync == selPrev_q) && (stableCnt_q >= delayCyc);
	assign autoEff = autoChangeEn && (delayMs != 16'h0000);
	assign confirmRise = pinSync_q[3] && !pinPrev_q[3];

	// qualification timer, restarted by any change of the sampled selection
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			selPrev_q <= `CPS_SEL_NEAR;
			stableCnt_q <= 32'h0000_0000;
		end else begin
			selPrev_q <= selSync;
			if (selSync != selPrev_q) begin
				stableCnt_q <= 32'h0000_0000;
			end else if (stableCnt_q != 32'hffff_ffff) begin
				stableCnt_q <= stableCnt_q + 32'h0000_0001;
			end
		end
	end

	// undefined ids never reach the program store; service mode blocks all changes
	always_comb begin
		accept = 1'b0;
		if (!serviceMode && (state_q == CPS_IDLE) && qualified && !selSync[1]) begin
			if (autoEff) begin
				accept = (selSync[0] != targetProg_q);
			end else begin
				accept = confirmRise;
			end
		end
	end

	// configuration gate: process mode and too-tight tolerances are refused
	assign tolBad = (cfgTolX < `CPS_TOL_MIN_MM) || (cfgTolY < `CPS_TOL_MIN_MM);
	assign reloadReq = cfgWrEn && serviceMode && !tolBad && (cfgProg == targetProg_q);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfgReject <= 1'b0;
		end else begin
			cfgReject <= cfgWrEn && (!serviceMode || tolBad);
		end
	end

	cps_prog_mem u_mem (
		.sys_clk(sys_clk),
		.rst(rst),
		.wrEn(cfgWrEn && serviceMode && !tolBad),
		.wrAddr(cfgProg),
		.wrData({cfgDiameter, cfgTolY, cfgTolX, cfgOffsetY, cfgOffsetX}),
		.rdEn(memRd),
		.rdAddr(targetProg_q),
		.rdData(memRdData)
	);

	assign memRd = (state_q == CPS_READ);

	// changeover: read the new program word, then load it; three cycles, far under 300 ms
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= CPS_IDLE;
			targetProg_q <= `CPS_PROG_RST;
		end else begin
			unique case (state_q)
				CPS_IDLE: begin
					if (accept) begin
						targetProg_q <= selSync[0];
						state_q <= CPS_READ;
					end else if (reloadReq) begin
						state_q <= CPS_READ;
					end
				end
				CPS_READ: begin
					state_q <= CPS_LOAD;
				end
				CPS_LOAD: begin
					state_q <= CPS_IDLE;
				end
				default: begin
					state_q <= CPS_IDLE;
				end
			endcase
		end
	end

	// active program word and status flags
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			activeCfg_q <= `CPS_CFG_RST;
			activeProgram <= `CPS_PROG_RST;
			changeBusy <= 1'b0;
			undefinedSel <= 1'b0;
		end else begin
			if (state_q == CPS_LOAD) begin
				activeCfg_q <= memRdData;
				activeProgram <= targetProg_q;
			end
			changeBusy <= (state_q != CPS_IDLE) || accept || reloadReq;
			undefinedSel <= selSync[1];
		end
	end

	assign offX = activeCfg_q[`CPS_OFFY_LSB-1:`CPS_OFFX_LSB];
	assign offY = activeCfg_q[`CPS_TOLX_LSB-1:`CPS_OFFY_LSB];
	assign tolX = activeCfg_q[`CPS_TOLY_LSB-1:`CPS_TOLX_LSB];
	assign tolY = activeCfg_q[`CPS_DIAM_LSB-1:`CPS_TOLY_LSB];
	assign diam = activeCfg_q[`CPS_CFG_W-1:`CPS_DIAM_LSB];

	// doubled coordinates avoid halving an odd diameter: |2*dev| <= diam + 2*tol
	assign devX2 = 18'(measX - offX) <<< 1;
	assign devY2 = 18'(measY - offY) <<< 1;
	assign limX = 18'({1'b0, diam}) + 18'({tolX, 1'b0});
	assign limY = 18'({1'b0, diam}) + 18'({tolY, 1'b0});
	assign insideX = (devX2 <= limX) && (devX2 >= -limX);
	assign insideY = (devY2 <= limY) && (devY2 >= -limY);

	// positioning lines five to eight, updated per measurement, dark in service mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pos_out_neg_x <= 1'b0;
			pos_out_pos_x <= 1'b0;
			pos_out_pos_y <= 1'b0;
			pos_out_neg_y <= 1'b0;
		end else if (serviceMode) begin
			pos_out_neg_x <= 1'b0;
			pos_out_pos_x <= 1'b0;
			pos_out_pos_y <= 1'b0;
			pos_out_neg_y <= 1'b0;
		end else if (measValid) begin
			if (insideX && insideY) begin
				pos_out_neg_x <= 1'b1;
				pos_out_pos_x <= 1'b1;
				pos_out_pos_y <= 1'b1;
				pos_out_neg_y <= 1'b1;
			end else begin
				pos_out_neg_x <= (devX2 < -limX);
				pos_out_pos_x <= (devX2 > limX);
				pos_out_pos_y <= (devY2 > limY);
				pos_out_neg_y <= (devY2 < -limY);
			end
		end
	end

	// trigger and fault-image lines: levels plus a start pulse on each rising edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			readingGateOpen <= 1'b0;
			programStart <= 1'b0;
			faultMemActive <= 1'b0;
			imageWriteStart <= 1'b0;
		end else begin
			readingGateOpen <= pinSync_q[0] && !serviceMode;
			programStart <= pinSync_q[0] && !pinPrev_q[0] && !serviceMode;
			faultMemActive <= pinSync_q[4] && !serviceMode;
			imageWriteStart <= pinSync_q[4] && !pinPrev_q[4] && !serviceMode;
		end
	end

	property p_cfg_proc_reject;
		@(posedge sys_clk) disable iff (rst)
		(cfgWrEn && !serviceMode) |=> cfgReject;
	endproperty
	a_cfg_proc_reject: assert property (p_cfg_proc_reject) else $error("write in process mode not refused");

	property p_tol_min;
		@(posedge sys_clk) disable iff (rst)
		(cfgWrEn && (cfgTolX < 8'h02)) |=> cfgReject;
	endproperty
	a_tol_min: assert property (p_tol_min) else $error("tolerance under minimum accepted");

	property p_svc_dark;
		@(posedge sys_clk) disable iff (rst)
		serviceMode |=> !(pos_out_neg_x || pos_out_pos_x || pos_out_pos_y || pos_out_neg_y
			|| readingGateOpen || faultMemActive);
	endproperty
	a_svc_dark: assert property (p_svc_dark) else $error("switching lines active in service");

	property p_all_one;
		@(posedge sys_clk) disable iff (rst)
		(measValid && !serviceMode && insideX && insideY) |=>
			(pos_out_neg_x && pos_out_pos_x && pos_out_pos_y && pos_out_neg_y);
	endproperty
	a_all_one: assert property (p_all_one) else $error("inside area but outputs not all one");

	property p_change_done;
		@(posedge sys_clk) disable iff (rst)
		accept |-> ##3 (activeProgram == $past(selSync[0], 3)) && (state_q == CPS_IDLE);
	endproperty
	a_change_done: assert property (p_change_done) else $error("changeover not completed");

	property p_zero_delay;
		@(posedge sys_clk) disable iff (rst)
		(delayMs == 16'h0000 && !confirmRise) |-> !accept;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("auto change with zero delay");

	property p_manual_confirm;
		@(posedge sys_clk) disable iff (rst)
		(accept && !autoEff) |-> confirmRise;
	endproperty
	a_manual_confirm: assert property (p_manual_confirm) else $error("manual change without confirm");

	property p_stable;
		@(posedge sys_clk) disable iff (rst)
		accept |-> (stableCnt_q >= delayCyc) && (selSync == $past(selSync)) && !selSync[1];
	endproperty
	a_stable: assert property (p_stable) else $error("change accepted before delay");

	property p_restart;
		@(posedge sys_clk) disable iff (rst)
		(selSync != selPrev_q) |=> (stableCnt_q == 32'h0000_0000);
	endproperty
	a_restart: assert property (p_restart) else $error("delay counter not restarted");
endmodule

// ===== hw/cps_pkg.sv
// types shared by the check program select block
// assumes cps_regs.svh for the numeric constants
package cps_pkg;
	typedef enum logic [2:0] {
		CPS_IDLE = 3'b001,
		CPS_READ = 3'b010,
		CPS_LOAD = 3'b100
	} cps_chg_state_t;
	typedef logic [1:0] cps_sel_t;
endpackage

// ===== hw/cps_prog_mem.sv
// per-program configuration store, one word per check program, registered read data
// assumes a single clock; writes and reads are same-domain strobes
`include "cps_regs.svh"
module cps_prog_mem
	import cps_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic wrAddr,
	input wire logic [`CPS_CFG_W-1:0] wrData,
	input wire logic rdEn,
	input wire logic rdAddr,
	output logic [`CPS_CFG_W-1:0] rdData
);
	logic [`CPS_CFG_W-1:0] mem_q [2];

	// each entry starts from the factory default so a changeover never loads unknowns
	for (genvar e = 0; e < 2; e++) begin : g_entry
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				mem_q[e] <= `CPS_CFG_RST;
			end else if (wrEn && (wrAddr == 1'(e))) begin
				mem_q[e] <= wrData;
			end
		end
	end

	// read data held in a register until the next read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdData <= `CPS_CFG_RST;
		end else if (rdEn) begin
			rdData <= mem_q[rdAddr];
		end
	end
endmodule

// ===== hw/cps_regs.svh
// constants for the check program select block: timing counts, field layout, reset values
// assumes a 20 MHz system clock; included by the select block and the program store design files
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

`define CPS_CLK_HZ 20000000
`define CPS_MS_PER_S 1000
`define CPS_CYC_PER_MS (`CPS_CLK_HZ / `CPS_MS_PER_S)
`define CPS_CHANGE_MAX_MS 300
`define CPS_CHANGE_MAX_CYC (`CPS_CHANGE_MAX_MS * `CPS_CYC_PER_MS)
`define CPS_TOL_MIN_MM 8'h02
`define CPS_SEL_NEAR 2'h0
`define CPS_SEL_FAR 2'h1
`define CPS_PROG_RST 1'h0
`define CPS_CFG_W 56
`define CPS_OFFX_LSB 0
`define CPS_OFFY_LSB 16
`define CPS_TOLX_LSB 32
`define CPS_TOLY_LSB 40
`define CPS_DIAM_LSB 48
`define CPS_CFG_RST 56'h0f_0505_0000_0000

`endif
